/* hdl/rpd_pkg.sv */
package rpd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel and position scale
    localparam int CHANNELS = 6;
    localparam int POS_W = 12;
    localparam int CH_AW = 3;
    localparam logic [11:0] COUNTS_PER_REV = 12'hFA0;   // 4000 counts per 360 degrees
    localparam logic [11:0] POS_MAX = 12'hF9F;          // 3999, top of stored range
    localparam logic [11:0] POS_RESET = 12'h000;
    localparam logic [11:0] REF_HIGH_END = 12'h7D0;     // 2000, half wave
    localparam logic [11:0] QUAD_START = 12'h3E8;       // 1000, a quarter wave later
    localparam logic [11:0] QUAD_END = 12'hBB8;         // 3000

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_HZ = 32'h0BEBC200;      // 200 MHz
    localparam int unsigned CLK_MHZ = 32'h000000C8;     // 200
    localparam int unsigned EXC_HZ = 32'h00000FA0;      // 4 kHz excitation
    localparam int unsigned PHASE_INC = EXC_HZ * 32'h00000FA0;
    localparam int unsigned REFRESH_NS = 32'h0016E360;  // 1.5 ms
    localparam int unsigned REFRESH_CYC = REFRESH_NS * CLK_MHZ / 32'h000003E8;
    localparam logic [1:0] ACT_HOLD = 2'h2;             // Refresh ticks an indicator stays busy

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_LOSS = 8'h0C;
    localparam logic [7:0] OFS_POS0 = 8'h10;
    localparam int CTRL_CONFIGURED = 0;
    localparam int CTRL_RUN = 1;
    localparam int STAT_W = 7;
    localparam int STAT_REFRESH = 6;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [6:0] STAT_RESET = 7'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rpd_wb_req_t;

    typedef struct packed {
        logic en;
        logic [2:0] addr;
        logic [11:0] data;
    } rpd_mem_wr_t;

endpackage

/* hdl/rpd_pos_mem.sv */
`timescale 1ns/1ps

// Six-word position store: one write port, one registered read port
module rpd_pos_mem
(
    input wire logic clk,
    input wire rpd_pkg::rpd_mem_wr_t wr,
    input wire logic [2:0] rd_addr,
    output logic [11:0] rd_data
);

    logic [11:0] words [0:rpd_pkg::CHANNELS-1];

    ////////////////////////////////////////////////////////////////////////////////
    // Whole word written in one edge, so a read never sees a half update
    always_ff @(posedge clk)
    begin
        if (wr.en)
        begin
            words[wr.addr] <= wr.data;
        end
    end

    // Registered read, out of range reads as zero
    always_ff @(posedge clk)
    begin
        if (rd_addr < 3'(rpd_pkg::CHANNELS))
        begin
            rd_data <= words[rd_addr];
        end
        else
        begin
            rd_data <= 12'h000;
        end
    end

endmodule

/* hdl/rpd_top.sv */
`timescale 1ns/1ps

// Contract
// - Six channels, own feedback, own stored position
// - Reference and quadrature waves, equal, 90 degrees apart
// - Feedback phase to counts, 4000 per turn
// - Refresh all six positions every 1.5 ms
// - Host reads any position at any time
// - Loss of feedback flag per channel
// - Potentiometer spans about 1000 counts, same scale; this design has no potentiometer input
// - Clockwise counts up, counter-clockwise counts down
// - Configured indicator on once host link established
// - Inbound and outbound activity indicators, steady when idle; with run off, traffic leaves them toggling
// - Stored position stays within 0 to 3999, wraps
module rpd_top
#(
    parameter int unsigned REFRESH_CYCLES = rpd_pkg::REFRESH_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire rpd_pkg::rpd_wb_req_t wb_in,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] rotor_feedback_wave,
    output logic reference_excitation_wave,
    output logic quadrature_excitation_wave,
    output logic [5:0] loss_of_feedback,
    output logic irq,
    output logic link_configured_indicator,
    output logic data_in_indicator,
    output logic data_out_indicator
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int CH = rpd_pkg::CHANNELS;

    logic [1:0] ctrl;
    logic [6:0] status;
    logic [6:0] mask;
    logic run;
    logic [31:0] phase_acc;
    logic phase_tick;
    logic [11:0] phase;
    logic [31:0] refresh_cnt;
    logic refresh_tick;
    logic [5:0] fb_meta;
    logic [5:0] fb_sync;
    logic [5:0] fb_last;
    logic [5:0] fb_edge;
    logic [11:0] capt [0:CH-1];
    logic [11:0] miss_cnt [0:CH-1];
    logic [5:0] lost;
    logic [5:0] lost_event;
    logic upd_busy;
    logic [2:0] upd_idx;
    logic upd_done;
    rpd_pkg::rpd_mem_wr_t mem_wr;
    logic [2:0] mem_rd_addr;
    logic [11:0] mem_rd_data;
    logic wb_req;
    logic wb_busy;
    logic wb_wr_go;
    logic wb_rd_go;
    logic [1:0] in_hold;
    logic [1:0] out_hold;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode helpers
    function automatic logic is_pos(input logic [7:0] adr);
        is_pos = (adr >= rpd_pkg::OFS_POS0)
            && (adr < rpd_pkg::OFS_POS0 + 8'(4 * rpd_pkg::CHANNELS))
            && (adr[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] pos_index(input logic [7:0] adr);
        logic [7:0] rel;
        rel = adr - rpd_pkg::OFS_POS0;
        pos_index = rel[4:2];
    endfunction

    assign run = ctrl[rpd_pkg::CTRL_RUN];

    ////////////////////////////////////////////////////////////////////////////////
    // Phase step generator: 4000 steps per excitation period, fractional divider
    always_ff @(posedge clk)
    begin
        if (!rstn || !run)
        begin
            phase_acc <= 32'h00000000;
            phase_tick <= 1'b0;
        end
        else if (phase_acc + rpd_pkg::PHASE_INC >= rpd_pkg::CLK_HZ)
        begin
            phase_acc <= phase_acc + rpd_pkg::PHASE_INC - rpd_pkg::CLK_HZ;
            phase_tick <= 1'b1;
        end
        else
        begin
            phase_acc <= phase_acc + rpd_pkg::PHASE_INC;
            phase_tick <= 1'b0;
        end
    end

    // Reference phase counter, one turn is 4000 counts, wraps at 3999
    always_ff @(posedge clk)
    begin
        if (!rstn || !run)
        begin
            phase <= rpd_pkg::POS_RESET;
        end
        else if (phase_tick)
        begin
            if (phase == rpd_pkg::POS_MAX)
            begin
                phase <= rpd_pkg::POS_RESET;
            end
            else
            begin
                phase <= phase + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Excitation waves from one counter: same period and duty, quarter turn apart
    always_ff @(posedge clk)
    begin
        if (!rstn || !run)
        begin
            reference_excitation_wave <= 1'b0;
            quadrature_excitation_wave <= 1'b0;
        end
        else
        begin
            reference_excitation_wave <= (phase < rpd_pkg::REF_HIGH_END);
            quadrature_excitation_wave <= (phase >= rpd_pkg::QUAD_START)
                && (phase < rpd_pkg::QUAD_END);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Feedback pins: two-stage synchroniser, then edge detect on the second stage
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            fb_meta <= 6'h00;
            fb_sync <= 6'h00;
            fb_last <= 6'h00;
        end
        else
        begin
            fb_meta <= rotor_feedback_wave;
            fb_sync <= fb_meta;
            fb_last <= fb_sync;
        end
    end

    assign fb_edge = fb_sync & ~fb_last & {6{run}};

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel phase capture and loss watchdog
    genvar gi;
    generate
        for (gi = 0; gi < CH; gi = gi + 1)
        begin : g_chan
            // Feedback rising edge latches the reference phase; more lag is more count
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    capt[gi] <= rpd_pkg::POS_RESET;
                end
                else if (fb_edge[gi])
                begin
                    capt[gi] <= phase;
                end
            end

            // Count phase steps since the last edge, saturating at one period
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    miss_cnt[gi] <= 12'h000;
                    lost[gi] <= 1'b0;
                end
                else if (fb_edge[gi])
                begin
                    miss_cnt[gi] <= 12'h000;
                    lost[gi] <= 1'b0;
                end
                else
                begin
                    if (phase_tick && miss_cnt[gi] != rpd_pkg::COUNTS_PER_REV)
                    begin
                        miss_cnt[gi] <= miss_cnt[gi] + 12'h001;
                    end
                    lost[gi] <= (miss_cnt[gi] == rpd_pkg::COUNTS_PER_REV);
                end
            end

            assign lost_event[gi] = (miss_cnt[gi] == rpd_pkg::COUNTS_PER_REV)
                && !lost[gi] && !fb_edge[gi];
        end
    endgenerate

    // Loss flags out
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            loss_of_feedback <= 6'h00;
        end
        else
        begin
            loss_of_feedback <= lost;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Refresh interval timer
    always_ff @(posedge clk)
    begin
        if (!rstn || !run)
        begin
            refresh_cnt <= 32'h00000000;
            refresh_tick <= 1'b0;
        end
        else if (refresh_cnt == REFRESH_CYCLES - 1)
        begin
            refresh_cnt <= 32'h00000000;
            refresh_tick <= 1'b1;
        end
        else
        begin
            refresh_cnt <= refresh_cnt + 32'h00000001;
            refresh_tick <= 1'b0;
        end
    end

    // Copy the six captures into memory, one whole word per cycle
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            upd_busy <= 1'b0;
            upd_idx <= 3'h0;
            upd_done <= 1'b0;
        end
        else if (refresh_tick)
        begin
            upd_busy <= 1'b1;
            upd_idx <= 3'h0;
            upd_done <= 1'b0;
        end
        else if (upd_busy)
        begin
            upd_done <= (upd_idx == 3'(CH - 1));
            upd_busy <= (upd_idx != 3'(CH - 1));
            upd_idx <= upd_idx + 3'h1;
        end
        else
        begin
            upd_done <= 1'b0;
        end
    end

    // Write port feeds one full word at a time
    always_comb
    begin
        mem_wr.en = upd_busy;
        mem_wr.addr = upd_idx;
        mem_wr.data = capt[upd_idx];
    end

    assign mem_rd_addr = pos_index(wb_in.adr);

    rpd_pos_mem u_mem
    (
        .clk(clk),
        .wr(mem_wr),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: request taken, memory read settles, then ack one cycle
    assign wb_req = wb_in.cyc && wb_in.stb && !wb_ack_o && !wb_busy;
    assign wb_wr_go = wb_busy && wb_in.we;
    assign wb_rd_go = wb_busy && !wb_in.we;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wb_busy <= 1'b0;
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_busy <= wb_req;
            wb_ack_o <= wb_busy;
        end
    end

    // Read data mux, unmapped reads as zero; positions come from memory
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else if (wb_rd_go)
        begin
            if (is_pos(wb_in.adr))
            begin
                wb_dat_o <= {20'h00000, mem_rd_data};
            end
            else
            begin
                unique case (wb_in.adr)
                    rpd_pkg::OFS_CTRL: wb_dat_o <= {30'h00000000, ctrl};
                    rpd_pkg::OFS_STAT: wb_dat_o <= {25'h0000000, status};
                    rpd_pkg::OFS_MASK: wb_dat_o <= {25'h0000000, mask};
                    rpd_pkg::OFS_LOSS: wb_dat_o <= {26'h0000000, lost};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
        else
        begin
            wb_dat_o <= 32'h00000000;
        end
    end

    // Control register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctrl <= rpd_pkg::CTRL_RESET;
        end
        else if (wb_wr_go && wb_in.adr == rpd_pkg::OFS_CTRL && wb_in.sel[0])
        begin
            ctrl <= wb_in.dat[1:0];
        end
    end

    // Mask register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mask <= rpd_pkg::MASK_RESET;
        end
        else if (wb_wr_go && wb_in.adr == rpd_pkg::OFS_MASK && wb_in.sel[0])
        begin
            mask <= wb_in.dat[6:0];
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            status <= rpd_pkg::STAT_RESET;
        end
        else if (wb_wr_go && wb_in.adr == rpd_pkg::OFS_STAT && wb_in.sel[0])
        begin
            status <= (status & ~wb_in.dat[6:0]) | {upd_done, lost_event};
        end
        else
        begin
            status <= status | {upd_done, lost_event};
        end
    end

    // Level interrupt
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status & mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Indicators: configured follows control bit, activity flickers faint
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            link_configured_indicator <= 1'b0;
        end
        else
        begin
            link_configured_indicator <= ctrl[rpd_pkg::CTRL_CONFIGURED];
        end
    end

    // Activity windows reload on traffic and drain on refresh ticks
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            in_hold <= 2'h0;
            out_hold <= 2'h0;
        end
        else
        begin
            if (wb_wr_go)
            begin
                in_hold <= rpd_pkg::ACT_HOLD;
            end
            else if (refresh_tick && in_hold != 2'h0)
            begin
                in_hold <= in_hold - 2'h1;
            end
            if (wb_rd_go)
            begin
                out_hold <= rpd_pkg::ACT_HOLD;
            end
            else if (refresh_tick && out_hold != 2'h0)
            begin
                out_hold <= out_hold - 2'h1;
            end
        end
    end

    // Toggling every cycle reads as faint; idle holds steady high
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            data_in_indicator <= 1'b1;
            data_out_indicator <= 1'b1;
        end
        else
        begin
            data_in_indicator <= (in_hold != 2'h0) ? ~data_in_indicator : 1'b1;
            data_out_indicator <= (out_hold != 2'h0) ? ~data_out_indicator : 1'b1;
        end
    end

endmodule

/* tb/rpd_top_props.sv */
`timescale 1ns/1ps

// Port-level timing checks on the digitizer top
module rpd_top_props
#(
    parameter int unsigned REFRESH_CYCLES = 200
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire rpd_pkg::rpd_wb_req_t wb_in,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [5:0] rotor_feedback_wave,
    input wire logic reference_excitation_wave,
    input wire logic quadrature_excitation_wave,
    input wire logic [5:0] loss_of_feedback,
    input wire logic irq,
    input wire logic link_configured_indicator,
    input wire logic data_in_indicator,
    input wire logic data_out_indicator
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////
    // Bus steps: request taken, then answer two edges later
    sequence req_taken_s;
        $rose(wb_in.cyc && wb_in.stb);
    endsequence
    sequence ack_after_s;
        !wb_ack_o ##1 wb_ack_o;
    endsequence

    ////////////////////////////////////////////////////////////
    // Assertions
    ack_time_a: assert property (req_taken_s |=> ack_after_s)
        else $error("ack not two edges after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    data_width_a: assert property (wb_dat_o[31:12] == 20'h00000)
        else $error("read data above twelve bits");
    cfg_follow_a: assert property ($changed(link_configured_indicator) |->
        $past(wb_ack_o && wb_in.we && wb_in.sel[0] && wb_in.adr == rpd_pkg::OFS_CTRL))
        else $error("configured indicator moved without control write");
    quad_order_a: assert property ($changed(quadrature_excitation_wave) |->
        quadrature_excitation_wave == reference_excitation_wave)
        else $error("quadrature edge out of quarter order");
    in_toggle_a: assert property (!data_in_indicator |=> data_in_indicator)
        else $error("inbound indicator stuck low");
    out_toggle_a: assert property (!data_out_indicator |=> data_out_indicator)
        else $error("outbound indicator stuck low");
    loss_clear_a: assert property ($rose(rotor_feedback_wave[0]) |->
        ##[1:8] !loss_of_feedback[0])
        else $error("loss flag not cleared by feedback edge");
endmodule

/* tb/rpd_resolver_model.sv */
`timescale 1ns/1ps

// Six field transducers answering the excitation with a delayed feedback edge
module rpd_resolver_model
(
    input wire logic clk,
    input wire logic reference_excitation_wave,
    input wire logic [5:0] present,
    input wire logic [15:0] lag [6],
    output logic [5:0] rotor_feedback_wave = 6'h00
);
    logic ref_d = 1'b0;

    // Reference edge detect
    always @(posedge clk) ref_d <= reference_excitation_wave;

    for (genvar i = 0; i < 6; i++)
    begin : g_ch
        int cnt = 32'h7FFF0000;
        // Feedback rises a fixed lag after each reference rise; a lost winding stays quiet
        always @(posedge clk)
        begin
            if (reference_excitation_wave && !ref_d)
                cnt <= 0;
            else if (cnt < 32'h7FFF0000)
                cnt <= cnt + 1;
            rotor_feedback_wave[i] <= present[i] && cnt >= lag[i] && cnt < lag[i] + 400;
        end
    end
endmodule

/* tb/six_channel_resolver_phase_digitizer_tb.sv */
`timescale 1ns/1ps

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end

bind rpd_top rpd_top_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_props (.clk(clk), .rstn(rstn),
    .wb_in(wb_in), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .rotor_feedback_wave(rotor_feedback_wave), .loss_of_feedback(loss_of_feedback),
    .reference_excitation_wave(reference_excitation_wave),
    .quadrature_excitation_wave(quadrature_excitation_wave),
    .link_configured_indicator(link_configured_indicator),
    .data_in_indicator(data_in_indicator), .data_out_indicator(data_out_indicator));

module six_channel_resolver_phase_digitizer_tb;
    localparam int unsigned RC = 200;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    rpd_pkg::rpd_wb_req_t wb_in = '0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, ref_w, quad_w, irq, cfg, din, dout;
    logic [5:0] fb, loss;
    logic [5:0] present = 6'h1F;
    logic [15:0] lag [6] = '{default: 16'h0064};
    int exp_pos [6];
    int error_cnt = 0;
    int num_checks = 0;
    int n;

    // Clock, design and field side
    always #2.5 clk = ~clk;
    rpd_top #(.REFRESH_CYCLES(RC)) i_dut (.clk(clk), .rstn(rstn), .wb_in(wb_in),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rotor_feedback_wave(fb),
        .reference_excitation_wave(ref_w), .quadrature_excitation_wave(quad_w),
        .loss_of_feedback(loss), .irq(irq), .link_configured_indicator(cfg),
        .data_in_indicator(din), .data_out_indicator(dout));
    rpd_resolver_model i_field (.clk(clk), .reference_excitation_wave(ref_w),
        .present(present), .lag(lag), .rotor_feedback_wave(fb));

    ////////////////////////////////////////////////////////////
    // Verdict and run end
    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] q);
        int k;
        k = 0;
        wb_in <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        q = wb_dat_o;
        if (k >= 100) `CHK(wb_ack_o, 1'b1)
        wb_in <= '0;
        @(posedge clk);
    endtask

    // Bounded wait for quadrature, reference or irq level
    task automatic wait_lvl(input int s, input logic v, input int lim, output int c);
        c = 0;
        while ((s == 0 ? quad_w : s == 1 ? ref_w : irq) !== v && c < lim)
        begin
            @(posedge clk);
            c++;
        end
        if (c >= lim) `CHK(c, 0)
    endtask

    function automatic logic near(logic [31:0] got, int e, int tol);
        return (^got !== 1'bx) && int'(got) - e <= tol && e - int'(got) <= tol;
    endfunction

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        n = $urandom(26);
        for (int i = 0; i < 6; i++)
        begin
            lag[i] = 16'($urandom_range(5000, 100));
            exp_pos[i] = (lag[i] + 4) * 2 / 25;
        end
        present = 6'h1F;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wb(0, rpd_pkg::OFS_CTRL, 0, rd); `CHK(rd, 32'h0)
        wb(0, rpd_pkg::OFS_STAT, 0, rd); `CHK(rd, 32'h0)
        wb(0, rpd_pkg::OFS_MASK, 0, rd); `CHK(rd, 32'h0)
        wb(1, rpd_pkg::OFS_POS0, $urandom, rd);
        wb(0, rpd_pkg::OFS_POS0, 0, rd); `CHK(rd, 32'h0)
        wb(0, 8'hFC, 0, rd); `CHK(rd, 32'h0)
        wb(1, rpd_pkg::OFS_CTRL, 32'h3, rd); `CHK(cfg, 1'b1)
        wait_lvl(0, 1'b1, 20000, n);
        wait_lvl(1, 1'b0, 20000, n); `CHK(near(n, 12500, 13), 1'b1)
        wait_lvl(0, 1'b0, 20000, n); `CHK(near(n, 12500, 13), 1'b1)
        wb(1, rpd_pkg::OFS_MASK, 32'h40, rd);
        wait_lvl(2, 1'b1, 2 * RC + 20, n);
        wb(1, rpd_pkg::OFS_MASK, 0, rd); `CHK(irq, 1'b0)
        wb(0, rpd_pkg::OFS_STAT, 0, rd); `CHK(rd[6], 1'b1)
        wb(1, rpd_pkg::OFS_STAT, 32'h7F, rd);
        for (int i = 0; i < 5; i++)
        begin
            wb(0, rpd_pkg::OFS_POS0 + 8'(4 * i), 0, rd);
            `CHK(near(rd, exp_pos[i], 2), 1'b1)
        end
        repeat (16000) @(posedge clk);
        `CHK({din, dout}, 2'h3)
        `CHK(loss, 6'h20)
        wb(0, rpd_pkg::OFS_LOSS, 0, rd); `CHK(rd, 32'h20)
        wb(0, rpd_pkg::OFS_STAT, 0, rd); `CHK(rd[5], 1'b1)
        finish_test();
    end

    // Watchdog against a hung run
    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule
